// *** rtl/adc_ctrl_pkg.sv ***
// package: register map, field positions, reset values and carriers
// assumes a single 250 MHz clock domain and 32-bit register accesses
`default_nettype none
package adc_ctrl_pkg;
    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [5:0] PIN0_CTRL_OFS  = 6'h00;
    localparam logic [5:0] PIN3_CTRL_OFS  = 6'h0c;
    localparam logic [5:0] GEN_CTRL_OFS   = 6'h20;
    localparam int         NUM_PINS       = 4;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int         DEST_LSB       = 8;
    localparam int         PIN_EN_BIT     = 0;
    localparam int         GEN_EN_BIT     = 0;
    localparam int         CAL_BIT        = 1;
    localparam int         SPP_LSB        = 8;
    localparam int         WIDTH_LSB      = 16;
    localparam int         DROP_BIT       = 24;
    localparam logic [1:0] WIDTH_RST      = 2'h1;
    localparam logic [7:0] SPP_RST        = 8'h01;
    localparam logic       DROP_RST       = 1'b1;
    localparam logic [1:0] WIDTH_8        = 2'h0;
    localparam logic [1:0] WIDTH_16       = 2'h1;
    localparam logic [1:0] WIDTH_32       = 2'h3;
    localparam logic [2:0] CAL_PULSES     = 3'h6;
    localparam int         RESULT_W       = 12;
    localparam int         PAD_32         = 20;
    localparam logic [7:0] END_TOKEN      = 8'h01;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic        valid;
        logic        ctrl;
        logic [7:0]  data;
    } net_byte_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HDR  = 4'b0010,
        ST_DATA = 4'b0100,
        ST_END  = 4'b1000
    } tx_state_t;
endpackage
`default_nettype wire

// *** rtl/adc_ctrl.sv ***
// adc control: registers, trigger sequencing, sample formatting, packet sender
// assumes converter answers each start with one conv_done pulse and a 12-bit result
`default_nettype none
module adc_ctrl (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire adc_ctrl_pkg::reg_req_t  reg_req,
    output logic [31:0]                  reg_rdata_q,
    output logic                         reg_ack_q,
    input  wire logic                    trigger,
    output logic                         conv_on_q,
    output logic                         conv_start_q,
    output logic [1:0]                   conv_pin_q,
    output logic                         conv_cal_q,
    input  wire logic                    conv_done,
    input  wire logic [11:0]             conv_result,
    output adc_ctrl_pkg::net_byte_t      tx_q,
    input  wire logic                    tx_ready
);
    import adc_ctrl_pkg::*;

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [23:0] dest_q [NUM_PINS];
    logic [23:0] dest_d [NUM_PINS];
    logic [NUM_PINS-1:0] pin_en_q, pin_en_d;
    logic        gen_en_q, gen_en_d, cal_q, cal_d, drop_q, drop_d;
    logic [1:0]  width_q, width_d;
    logic [7:0]  spp_q, spp_d;
    logic [31:0] rdata_d;
    logic        drop_evt;
    logic        access;
    logic [1:0]  pidx;

    assign access = reg_req.wr | reg_req.rd;
    assign pidx   = reg_req.addr[3:2];

    // decode writes, reads and the dropped-sample flag
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            dest_d[i] = dest_q[i];
        end
        pin_en_d = pin_en_q;
        gen_en_d = gen_en_q;
        cal_d    = cal_q;
        width_d  = width_q;
        spp_d    = spp_q;
        drop_d   = drop_q;
        rdata_d  = reg_rdata_q;
        if (reg_req.wr && reg_req.addr <= PIN3_CTRL_OFS && reg_req.addr[1:0] == 2'h0
            && !gen_en_q) begin
            dest_d[pidx]   = reg_req.wdata[31:DEST_LSB];
            pin_en_d[pidx] = reg_req.wdata[PIN_EN_BIT];
        end
        if (reg_req.wr && reg_req.addr == GEN_CTRL_OFS) begin
            gen_en_d = reg_req.wdata[GEN_EN_BIT];
            cal_d    = reg_req.wdata[CAL_BIT];
            width_d  = reg_req.wdata[WIDTH_LSB+:2];
            spp_d    = reg_req.wdata[SPP_LSB+:8];
        end
        if (reg_req.rd) begin
            rdata_d = 32'h0000_0000;
            if (reg_req.addr <= PIN3_CTRL_OFS && reg_req.addr[1:0] == 2'h0) begin
                rdata_d = {dest_q[pidx], 7'h00, pin_en_q[pidx]};
            end else if (reg_req.addr == GEN_CTRL_OFS) begin
                rdata_d = {7'h00, drop_q, 6'h00, width_q, spp_q, 6'h00, cal_q, gen_en_q};
                drop_d  = 1'b0;
            end
        end
        if (drop_evt) begin
            drop_d = 1'b1;                                  // set wins over read clear
        end
    end

    // register the control state
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_PINS; i++) begin
                dest_q[i] <= 24'h000000;
            end
            pin_en_q    <= '0;
            gen_en_q    <= 1'b0;
            cal_q       <= 1'b0;
            width_q     <= WIDTH_RST;
            spp_q       <= SPP_RST;
            drop_q      <= DROP_RST;
            reg_rdata_q <= 32'h0000_0000;
            reg_ack_q   <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                dest_q[i] <= dest_d[i];
            end
            pin_en_q    <= pin_en_d;
            gen_en_q    <= gen_en_d;
            cal_q       <= cal_d;
            width_q     <= width_d;
            spp_q       <= spp_d;
            drop_q      <= drop_d;
            reg_rdata_q <= rdata_d;
            reg_ack_q   <= access;
        end
    end

    // ------------------------------------------------------------
    // trigger sequencing and calibration pulses
    // ------------------------------------------------------------
    logic       trig_q, trig_rise;
    logic [2:0] cal_cnt_q, cal_cnt_d;
    logic [1:0] last_pin_q, last_pin_d, next_pin;
    logic       any_en, start_d, calconv_q, calconv_d;

    assign trig_rise = trigger & ~trig_q;
    assign any_en    = |pin_en_q;

    // pick the next enabled pin after the last one converted
    always_comb begin
        next_pin = last_pin_q;
        for (int k = NUM_PINS; k >= 1; k--) begin
            if (pin_en_q[2'(last_pin_q + 2'(k))]) begin
                next_pin = 2'(last_pin_q + 2'(k));
            end
        end
    end

    // issue one conversion per trigger edge; first six are calibration only
    always_comb begin
        cal_cnt_d  = cal_cnt_q;
        last_pin_d = last_pin_q;
        start_d    = 1'b0;
        calconv_d  = calconv_q;
        if (!gen_en_q) begin
            cal_cnt_d = 3'h0;                               // re-enable restarts calibration
        end else if (trig_rise) begin
            if (cal_cnt_q < CAL_PULSES) begin
                cal_cnt_d = cal_cnt_q + 3'h1;
                start_d   = 1'b1;
                calconv_d = 1'b1;
            end else if (any_en) begin
                start_d    = 1'b1;
                calconv_d  = 1'b0;
                last_pin_d = next_pin;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            trig_q       <= 1'b0;
            cal_cnt_q    <= 3'h0;
            last_pin_q   <= 2'h3;
            calconv_q    <= 1'b0;
            conv_start_q <= 1'b0;
            conv_pin_q   <= 2'h0;
            conv_on_q    <= 1'b0;
            conv_cal_q   <= 1'b0;
        end else begin
            trig_q       <= trigger;
            cal_cnt_q    <= cal_cnt_d;
            last_pin_q   <= last_pin_d;
            calconv_q    <= calconv_d;
            conv_start_q <= start_d;
            conv_pin_q   <= last_pin_d;
            conv_on_q    <= gen_en_q;
            conv_cal_q   <= cal_q;
        end
    end

    // ------------------------------------------------------------
    // pending sample and packet sender
    // ------------------------------------------------------------
    tx_state_t   st_q, st_d;
    logic        pend_q, pend_d, open_q, open_d, close_q, close_d;
    logic [31:0] word_q, word_d;
    logic [1:0]  ppin_q, ppin_d, opin_q, opin_d, idx_q, idx_d, last_byte;
    logic [7:0]  cnt_q, cnt_d;
    net_byte_t   tx_d;
    logic        go;

    assign go        = ~tx_q.valid | tx_ready;             // one byte held until taken
    assign last_byte = (width_q == WIDTH_8) ? 2'h0 : (width_q == WIDTH_32) ? 2'h3 : 2'h1;

    // drop happens only with a live sample still waiting; calibration results vanish
    assign drop_evt = conv_done & ~calconv_q & pend_q;

    always_comb begin
        st_d    = st_q;
        pend_d  = pend_q;
        open_d  = open_q;
        close_d = close_q | (access & open_q);
        word_d  = word_q;
        ppin_d  = ppin_q;
        opin_d  = opin_q;
        idx_d   = idx_q;
        cnt_d   = cnt_q;
        tx_d    = tx_q;
        tx_d.valid = tx_q.valid & ~tx_ready;
        case (st_q)
            ST_IDLE: begin
                if (!open_q) begin
                    close_d = 1'b0;
                end
                if (open_q && close_q) begin
                    st_d = ST_END;
                end else if (pend_q) begin
                    idx_d = 2'h0;
                    if (open_q && opin_q == ppin_q) begin
                        st_d = ST_DATA;
                    end else if (open_q) begin
                        st_d = ST_END;
                    end else begin
                        st_d   = ST_HDR;
                        opin_d = ppin_q;
                    end
                end
            end
            ST_HDR: begin
                if (go) begin
                    tx_d  = '{valid: 1'b1, ctrl: 1'b0, data: dest_q[opin_q][8*(2-idx_q)+:8]};
                    idx_d = idx_q + 2'h1;
                    if (idx_q == 2'h2) begin
                        idx_d  = 2'h0;
                        open_d = 1'b1;
                        st_d   = ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (go) begin
                    // high byte first in every width
                    tx_d  = '{valid: 1'b1, ctrl: 1'b0, data: word_q[8*(3-idx_q)+:8]};
                    idx_d = idx_q + 2'h1;
                    if (idx_q == last_byte) begin
                        pend_d = 1'b0;
                        cnt_d  = cnt_q + 8'h01;
                        st_d   = (spp_q != 8'h00 && cnt_q + 8'h01 == spp_q) ? ST_END : ST_IDLE;
                    end
                end
            end
            ST_END: begin
                if (go) begin
                    tx_d    = '{valid: 1'b1, ctrl: 1'b1, data: END_TOKEN};
                    open_d  = 1'b0;
                    close_d = 1'b0;
                    cnt_d   = 8'h00;
                    st_d    = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
        if (conv_done && !calconv_q && !pend_q) begin
            pend_d = 1'b1;
            ppin_d = conv_pin_q;
            word_d = {conv_result, 20'h00000};
            if (width_q == WIDTH_8) begin
                word_d = {conv_result[11:4], 24'h000000};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_q    <= ST_IDLE;
            pend_q  <= 1'b0;
            open_q  <= 1'b0;
            close_q <= 1'b0;
            word_q  <= 32'h0000_0000;
            ppin_q  <= 2'h0;
            opin_q  <= 2'h0;
            idx_q   <= 2'h0;
            cnt_q   <= 8'h00;
            tx_q    <= '0;
        end else begin
            st_q    <= st_d;
            pend_q  <= pend_d;
            open_q  <= open_d;
            close_q <= close_d;
            word_q  <= word_d;
            ppin_q  <= ppin_d;
            opin_q  <= opin_d;
            idx_q   <= idx_d;
            cnt_q   <= cnt_d;
            tx_q    <= tx_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    property p_pin_locked;
        gen_en_q && reg_req.wr && reg_req.addr == PIN3_CTRL_OFS
            |=> $stable(dest_q[3]) && $stable(pin_en_q);
    endproperty
    a_pin_locked: assert property (p_pin_locked) else $error("pin register changed while enabled");

    property p_drop_set;
        drop_evt |=> drop_q;
    endproperty
    a_drop_set: assert property (p_drop_set) else $error("dropped sample not flagged");

    property p_drop_clear;
        reg_req.rd && reg_req.addr == GEN_CTRL_OFS && !drop_evt |=> !drop_q;
    endproperty
    a_drop_clear: assert property (p_drop_clear) else $error("drop flag not cleared by read");

    property p_conv_gated;
        conv_start_q |-> conv_on_q || $past(gen_en_q);
    endproperty
    a_conv_gated: assert property (p_conv_gated) else $error("conversion while disabled");

    property p_start_enabled_pin;
        conv_start_q && !calconv_q |-> pin_en_q[conv_pin_q] || $past(pin_en_q[conv_pin_q]);
    endproperty
    a_start_enabled_pin: assert property (p_start_enabled_pin) else $error("disabled pin used");

    property p_cal_no_packet;
        conv_done && calconv_q && !pend_q |=> !pend_q;
    endproperty
    a_cal_no_packet: assert property (p_cal_no_packet) else $error("calibration sample queued");

    property p_cal_count;
        gen_en_q && trig_rise && cal_cnt_q == 3'h5 |=> cal_cnt_q == CAL_PULSES ##0 calconv_q;
    endproperty
    a_cal_count: assert property (p_cal_count) else $error("sixth pulse not counted");

    property p_live_after_cal;
        gen_en_q && trig_rise && cal_cnt_q == CAL_PULSES && any_en |=> conv_start_q && !calconv_q;
    endproperty
    a_live_after_cal: assert property (p_live_after_cal) else $error("seventh pulse not live");

    property p_pkt_len;
        st_q == ST_DATA && go && idx_q == last_byte && spp_q == 8'h01 |=> st_q == ST_END;
    endproperty
    a_pkt_len: assert property (p_pkt_len) else $error("packet not closed after count");

    property p_open_hold;
        st_q == ST_IDLE && open_q && !close_q && !pend_q && !access && spp_q == 8'h00
            |=> st_q == ST_IDLE && open_q;
    endproperty
    a_open_hold: assert property (p_open_hold) else $error("open packet closed early");

    property p_width8;
        conv_done && !calconv_q && !pend_q && width_q == WIDTH_8
            |=> word_q[31:24] == $past(conv_result[11:4]) && word_q[23:0] == 24'h000000;
    endproperty
    a_width8: assert property (p_width8) else $error("8-bit format wrong");

    property p_byte_hold;
        tx_q.valid && !tx_ready |=> tx_q.valid && $stable(tx_q.data);
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("byte lost under back-pressure");

    c_packet_end:  cover property (tx_q.valid && tx_q.ctrl && tx_ready);
    c_drop:        cover property (drop_evt);
    c_word32:      cover property (st_q == ST_DATA && width_q == WIDTH_32 && idx_q == 2'h3);
    c_access_cut:  cover property (open_q && access && spp_q == 8'h00);
endmodule
`default_nettype wire

// *** tb/net_sink.sv ***
// network sink model: collects packet bytes from the sender with random back-pressure
// assumes the sender holds each byte until tx_ready is seen high at a rising edge
`default_nettype none
module net_sink
    import adc_ctrl_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire adc_ctrl_pkg::net_byte_t tx_q,
    input  wire logic                    stall,
    output logic                         tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // receive side
    // ------------------------------------------------------------
    logic [8:0] rx_q[$];
    // ready changes at the falling edge; a stalled sink refuses all bytes
    initial begin
        tx_ready = 1'b0;
        forever @(negedge ref_clk) tx_ready = !stall && ($urandom_range(3) != 0);
    end
    // a byte is taken at the rising edge where valid meets ready
    always @(posedge ref_clk) begin
        if (rst_b && tx_q.valid && tx_ready) rx_q.push_back({tx_q.ctrl, tx_q.data});
    end
endmodule
`default_nettype wire

// *** tb/adc_ctrl_bench.sv ***
// bench: drives registers, trigger and converter; compares packets with a queue model
// assumes adc_ctrl_pkg, adc_ctrl and net_sink are compiled first
`default_nettype none
module adc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;
    logic        ref_clk, rst_b, trigger, conv_done, stall, tx_ready;
    logic        conv_on_q, conv_start_q, conv_cal_q, reg_ack_q;
    logic [1:0]  conv_pin_q;
    logic [11:0] conv_result, res;
    logic [31:0] reg_rdata_q, rd_v;
    reg_req_t    reg_req;
    net_byte_t   tx_q;
    int          fail_count, tests_run, cycles, starts, busy, cur_pin, last_pin;
    int          open_pin, cnt, wdt, spp, skip;
    logic [3:0]  mask;
    logic [23:0] dest[4];
    logic [8:0]  exp_q[$];
    adc_ctrl adc_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .reg_ack_q(reg_ack_q), .trigger(trigger),
        .conv_on_q(conv_on_q), .conv_start_q(conv_start_q), .conv_pin_q(conv_pin_q),
        .conv_cal_q(conv_cal_q), .conv_done(conv_done), .conv_result(conv_result),
        .tx_q(tx_q), .tx_ready(tx_ready));
    net_sink net_sink_inst (.ref_clk(ref_clk), .rst_b(rst_b), .tx_q(tx_q), .stall(stall),
        .tx_ready(tx_ready));
    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // packet model: header, left-aligned sample bytes, end token
    // ------------------------------------------------------------
    function automatic void push(logic [8:0] b);
        if (skip == 0) exp_q.push_back(b);
    endfunction
    // next enabled pin above the last one, wrapping round
    function automatic int next_en(int last, logic [3:0] m);
        for (int k = 1; k <= 4; k++) begin
            if (m[(last + k) % 4]) return (last + k) % 4;
        end
        return last;
    endfunction
    function automatic void close_pkt();
        push({1'b1, END_TOKEN});
        open_pin = -1;
    endfunction
    function automatic void sample(int pin, logic [11:0] r);
        if (open_pin >= 0 && open_pin != pin) close_pkt();
        if (open_pin < 0) begin
            push({1'b0, dest[pin][23:16]});
            push({1'b0, dest[pin][15:8]});
            push({1'b0, dest[pin][7:0]});
            open_pin = pin;
            cnt = 0;
        end
        push({1'b0, r[11:4]});
        if (wdt != 0) push({1'b0, r[3:0], 4'h0});
        if (wdt == 3) begin
            push(9'h000);
            push(9'h000);
        end
        cnt++;
        if (spp != 0 && cnt == spp) close_pkt();
    endfunction
    // ------------------------------------------------------------
    // converter model and clocking
    // ------------------------------------------------------------
    // a slow converter: done comes two to five cycles after each start
    always @(negedge ref_clk) begin
        if (busy > 0 && busy - 1 == 0) begin
            busy = 0;
            res = 12'($urandom);
            conv_done <= 1'b1;
            conv_result <= res;
            if (starts > 6) sample(cur_pin, res);
        end else begin
            if (busy > 0) busy--;
            conv_done <= 1'b0;
            conv_result <= 12'($urandom);
            if (conv_start_q === 1'b1) begin
                starts++;
                busy = 2 + $urandom_range(3);
                cur_pin = conv_pin_q;
                check("converter on", 1, conv_on_q);
                if (starts > 6) check("pin enabled", 1, mask[cur_pin]);
                if (starts > 7) check("pin turn", next_en(last_pin, mask), cur_pin);
                last_pin = cur_pin;
            end
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // hang guard, well above the longest expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 60000) begin
            fail_count++;
            end_sim();
        end
    end
    // ------------------------------------------------------------
    // bus and trigger tasks
    // ------------------------------------------------------------
    task automatic reg_acc(logic wr, logic [5:0] a, logic [31:0] wd);
        @(negedge ref_clk);
        reg_req = '{wr: wr, rd: !wr, addr: a, wdata: wd};
        @(negedge ref_clk);
        reg_req = '0;
        rd_v = reg_rdata_q;
        check("ack", 1, reg_ack_q);
        if (open_pin >= 0) close_pkt();
    endtask
    task automatic rd_chk(string what, logic [5:0] a, logic [31:0] exp);
        reg_acc(1'b0, a, 32'h0);
        check(what, exp, rd_v);
    endtask
    task automatic trig();
        @(negedge ref_clk);
        trigger = 1'b1;
        repeat (2) @(negedge ref_clk);
        trigger = 1'b0;
    endtask
    // waits for the converter and the sender to go quiet, bounded
    task automatic settle();
        int n;
        n = 0;
        while ((busy > 0 || tx_q.valid || net_sink_inst.rx_q.size() < exp_q.size()) && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (4) @(negedge ref_clk);
    endtask
    task automatic phase(int w, int s, logic cal, logic [3:0] m, int n);
        logic [31:0] g;
        logic [8:0]  got;
        g = {16'h0, 8'(s), 8'h0} | (32'(w) << 16) | {30'h0, cal, 1'b1};
        reg_acc(1'b1, GEN_CTRL_OFS, 32'h0);
        mask = m;
        wdt = w;
        spp = s;
        for (int p = 0; p < 4; p++) begin
            dest[p] = 24'($urandom);
            reg_acc(1'b1, 6'(4 * p), {dest[p], 7'h0, m[p]});
        end
        starts = 0;
        last_pin = -1;
        reg_acc(1'b1, GEN_CTRL_OFS, g);
        @(negedge ref_clk);
        check("converter enable", 1, conv_on_q);
        check("calibration", cal, conv_cal_q);
        reg_acc(1'b1, PIN3_CTRL_OFS, 32'h5a5a_5a00);
        rd_chk("pin3 locked", PIN3_CTRL_OFS, {dest[3], 7'h0, m[3]});
        for (int i = 0; i < 6 + n; i++) begin
            trig();
            settle();
        end
        check("starts", 6 + n, starts);
        if (s == 0) rd_chk("general", GEN_CTRL_OFS, g);
        settle();
        check("byte count", exp_q.size(), net_sink_inst.rx_q.size());
        while (exp_q.size() > 0 && net_sink_inst.rx_q.size() > 0) begin
            got = net_sink_inst.rx_q.pop_front();
            check("net byte", exp_q.pop_front(), got);
        end
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        trigger = 1'b0;
        stall = 1'b0;
        reg_req = '0;
        conv_done = 1'b0;
        conv_result = 12'h000;
        busy = 0;
        skip = 0;
        open_pin = -1;
        mask = 4'h0;
        void'($urandom(20770));
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        rd_chk("general reset", GEN_CTRL_OFS, 32'h0101_0100);
        rd_chk("general reread", GEN_CTRL_OFS, 32'h0001_0100);
        rd_chk("pin3 reset", PIN3_CTRL_OFS, 32'h0);
        reg_acc(1'b1, PIN3_CTRL_OFS, 32'hffff_ffff);
        rd_chk("pin3 rw", PIN3_CTRL_OFS, 32'hffff_ff01);
        reg_acc(1'b1, 6'h10, 32'hffff_ffff);
        rd_chk("unmapped", 6'h10, 32'h0);
        trig();
        repeat (6) @(negedge ref_clk);
        check("start while off", 0, starts);
        phase(0, 1, 1'b0, 4'b1000, 2);
        // cal switches on here and off next; the ideal converter mixes nothing
        phase(1, 2, 1'b1, 4'b1001, 4);
        phase(2, 1, 1'b0, 4'b0010, 1);
        phase(3, 3, 1'b0, 4'b0101, 3);
        phase(1, 0, 1'b0, 4'b1000, 3);
        // stalled sink: later samples find their predecessor unsent
        stall = 1'b1;
        skip = 1;
        phase(1, 1, 1'b0, 4'b1000, 3);
        rd_chk("dropped", GEN_CTRL_OFS, 32'h0101_0101);
        stall = 1'b0;
        settle();
        net_sink_inst.rx_q.delete();
        exp_q.delete();
        open_pin = -1;
        skip = 0;
        rd_chk("drop cleared", GEN_CTRL_OFS, 32'h0001_0101);
        end_sim();
    end
endmodule
`default_nettype wire
